// ===== verilog/flash_pes_params.svh
`ifndef FLASH_PES_PARAMS_SVH
`define FLASH_PES_PARAMS_SVH

// Command opcodes
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_READ_STATUS1 8'h05
`define OPC_READ_STATUS2 8'h35
`define OPC_PAGE_PROG 8'h02
`define OPC_QUAD_PROG 8'h32
`define OPC_SECTOR_ERASE 8'h20
`define OPC_BLOCK32_ERASE 8'h52
`define OPC_BLOCK64_ERASE 8'hD8
`define OPC_CHIP_ERASE_A 8'hC7
`define OPC_CHIP_ERASE_B 8'h60
`define OPC_SUSPEND 8'h75
`define OPC_RESUME 8'h7A

// Frame lengths in serial clocks
`define LEN_OPCODE 6'h08
`define LEN_ADDR_CMD 6'h20
`define LEN_SINGLE_MIN 6'h28
`define LEN_QUAD_MIN 6'h22
`define LEN_SAT 6'h3F
`define CNT_OPCODE_LAST 6'h07
`define CNT_ADDR_HI_LAST 6'h0F
`define CNT_ADDR_MID_LAST 6'h17
`define CNT_ADDR_LO_LAST 6'h1F

// Region sizes in bytes
`define SIZE_PAGE 25'h000_0100
`define SIZE_SECTOR 25'h000_1000
`define SIZE_BLOCK32 25'h000_8000
`define SIZE_BLOCK64 25'h001_0000
`define SIZE_ARRAY 25'h100_0000
`define PAGE_LAST 8'hFF

// Status bit positions
`define STAT_BUSY_BIT 0
`define STAT_LATCH_BIT 1
`define STAT_QUAD_BIT 1
`define STAT_SUSPEND_BIT 7

// Timing
`define MCLK_PERIOD_NS 20
`define RESUME_MAX_NS 200
`define RESUME_MAX_CYCLES (`RESUME_MAX_NS / `MCLK_PERIOD_NS)

`endif

// ===== verilog/flash_pes_pkg.sv
package flash_pes_pkg;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PROG = 3'h1,
    OP_SECTOR = 3'h2,
    OP_BLOCK32 = 3'h3,
    OP_BLOCK64 = 3'h4,
    OP_CHIP = 3'h5
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_FLUSH = 3'h4
  } state_e;

endpackage

// ===== verilog/flash_program_erase_suspend.sv
// What this block does
// RULE1: Quad page program is refused unless the quad data enable bit is one.
// RULE2: Host sends 32h, 24-bit address, then data bytes four bits per clock.
// RULE3: One program stores at most 256 bytes into erased cells only.
// RULE4: Quad page program is accepted only while the write enable latch is set.
// RULE5: Host holds chip select low for the whole program command.
// RULE6: Opcode 20h with address erases the addressed 4K sector to FFh.
// RULE7: Opcode 52h with address erases the addressed 32K block to ones.
// RULE8: Opcode D8h with address erases the addressed 64K block to ones.
// RULE9: Opcode C7h or 60h without address erases the whole array.
// RULE10: Every erase is accepted only while the write enable latch is one.
// RULE11: Addressed erase runs only if chip select rises right after bit 32.
// RULE12: Chip erase runs only if chip select rises right after bit 8.
// RULE13: Accepted operation runs self-timed with busy high, status still readable.
// RULE14: Completion of program or erase clears the write enable latch.
// RULE15: Sector or block erase on a protected or locked region is skipped.
// RULE16: Chip erase is skipped when any region is protected or locked.
// RULE17: Suspend 75h accepted only when not suspended and busy with erase/program.
// RULE18: Suspend during chip erase is ignored.
// RULE19: During erase suspend, status write and all erase opcodes are rejected.
// RULE20: During program suspend, status write and program opcodes are rejected.
// RULE21: Accepted suspend sets suspend flag at once, drops busy within latency.
// RULE22: Host waits the suspend latency after resume before suspending again.
// RULE23: Program data past the page end wraps to the same page start.
// RULE24: Resume 7Ah when suspended and idle clears flag, busy within 200ns.
// RULE25: Erase region comes from aligned upper address bits only.
// RULE26: Rejected commands leave busy, array and status bits unchanged.
`timescale 1ns/10ps
`include "flash_pes_params.svh"
module flash_program_erase_suspend #(
  // Self-timed cycle lengths; plain defaults, to be set for the real array
  parameter longint unsigned PROG_TIME_NS = 1000000,
  parameter longint unsigned SECTOR_ERASE_DURATION_NS = 1000000,
  parameter longint unsigned HALF_BLOCK_ERASE_DURATION_NS = 1000000,
  parameter longint unsigned BLOCK_ERASE_TIME_NS = 1000000,
  parameter longint unsigned CHIP_ERASE_TIME_NS = 1000000
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_data_line_0,
  input wire logic i_data_line_1,
  input wire logic i_data_line_2,
  input wire logic i_data_line_3,
  output logic o_data_line_0,
  output logic o_data_line_1,
  output logic o_data_line_2,
  output logic o_data_line_3,
  output logic o_data_line_0_oe_n,
  output logic o_data_line_1_oe_n,
  output logic o_data_line_2_oe_n,
  output logic o_data_line_3_oe_n,
  input wire logic i_quad_data_enable_bit,
  input wire logic i_block_protect_bit0,
  input wire logic i_block_protect_bit1,
  input wire logic i_block_protect_bit2,
  input wire logic i_protect_top_bottom_select,
  input wire logic i_protect_granularity_bit,
  input wire logic i_protect_complement_bit,
  input wire logic i_lock_hit,
  input wire logic i_any_lock,
  output logic o_busy,
  output logic o_write_enable_latch,
  output logic o_suspend_flag,
  output logic o_status_write_blocked,
  output logic [23:0] o_lock_addr,
  output logic o_arr_wr,
  output logic [23:0] o_arr_addr,
  output logic [7:0] o_arr_wdata,
  output logic o_arr_erase,
  output flash_pes_pkg::op_e o_arr_erase_kind,
  output logic [23:0] o_arr_erase_base
);
  import flash_pes_pkg::*;

  localparam longint unsigned PER = `MCLK_PERIOD_NS;
  localparam logic [31:0] PROG_CYCLES = 32'((PROG_TIME_NS + PER - 1) / PER);
  localparam logic [31:0] SECTOR_CYCLES = 32'((SECTOR_ERASE_DURATION_NS + PER - 1) / PER);
  localparam logic [31:0] B32_CYCLES = 32'((HALF_BLOCK_ERASE_DURATION_NS + PER - 1) / PER);
  localparam logic [31:0] B64_CYCLES = 32'((BLOCK_ERASE_TIME_NS + PER - 1) / PER);
  localparam logic [31:0] CHIP_CYCLES = 32'((CHIP_ERASE_TIME_NS + PER - 1) / PER);
  localparam int RESUME_MAX = `RESUME_MAX_CYCLES;

  // Link side, on the serial clock
  logic [5:0] link_cnt;
  logic [2:0] link_sub;
  logic [7:0] link_shift;
  logic [7:0] link_opcode;
  logic [23:0] link_addr;
  logic [5:0] link_len;
  logic link_aligned;
  logic [7:0] page_buf [256];
  logic [255:0] page_mask;
  logic [7:0] wr_ptr;
  logic [4:0] stat_s1;
  logic [4:0] stat_s2;
  logic link_quad;
  logic link_byte_done;
  logic link_is_prog;
  logic [7:0] next_shift;
  logic [2:0] next_sub;
  logic [5:0] next_cnt;
  logic [7:0] stat_byte;
  logic stat_read;

  // Controller side, on the main clock
  state_e state;
  state_e next_state;
  logic busy;
  logic write_enable_latch;
  logic suspend_flag;
  logic buf_lock;
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic decode;
  logic [7:0] cmd_opcode;
  logic [23:0] cmd_addr;
  logic [5:0] cmd_len;
  logic cmd_aligned;
  op_e act_op;
  logic [23:0] act_addr;
  logic [31:0] act_remain;
  op_e susp_op;
  logic [23:0] susp_addr;
  logic [31:0] susp_remain;
  logic [7:0] flush_idx;
  op_e new_op;
  logic [31:0] new_cycles;
  logic start_ok;
  logic start;
  logic susp_take;
  logic resume_take;
  logic latch_set;
  logic latch_clr;
  logic op_done;
  logic accepted;
  logic erase_suspended;
  logic prog_suspended;
  logic [2:0] prot_code;
  logic [24:0] prot_size;
  logic [24:0] prot_lo;
  logic [24:0] prot_hi;
  logic [24:0] t_size;
  logic [24:0] t_base;
  logic [24:0] t_end;
  logic prot_hit;
  logic lock_block;

  always_comb begin
    link_quad = (link_cnt >= `LEN_ADDR_CMD) && (link_opcode == `OPC_QUAD_PROG); // RULE2
    if (link_quad) begin
      next_shift = {link_shift[3:0], i_data_line_3, i_data_line_2, i_data_line_1, i_data_line_0};
    end else begin
      next_shift = {link_shift[6:0], i_data_line_0};
    end
    next_sub = link_sub + (link_quad ? 3'h4 : 3'h1);
    link_byte_done = (next_sub == 3'h0);
    next_cnt = (link_cnt == `LEN_SAT) ? link_cnt : link_cnt + 6'h01;
    link_is_prog = (link_opcode == `OPC_PAGE_PROG) || (link_opcode == `OPC_QUAD_PROG);
  end

  // Chip select high clears the frame position between frames
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      link_cnt <= 6'h00;
      link_sub <= 3'h0;
    end else begin
      link_cnt <= next_cnt;
      link_sub <= next_sub;
    end
  end

  // Frame contents stay put after chip select rises for the main clock to read
  always_ff @(posedge i_sclk) begin
    link_shift <= next_shift;
    link_len <= next_cnt;
    link_aligned <= link_byte_done;
    if (link_cnt == `CNT_OPCODE_LAST) begin
      link_opcode <= next_shift;
    end
    if (link_cnt == `CNT_ADDR_HI_LAST) begin
      link_addr[23:16] <= next_shift;
    end
    if (link_cnt == `CNT_ADDR_MID_LAST) begin
      link_addr[15:8] <= next_shift;
    end
    if (link_cnt == `CNT_ADDR_LO_LAST) begin
      link_addr[7:0] <= next_shift;
      wr_ptr <= next_shift;
    end
    if (link_cnt >= `LEN_ADDR_CMD && link_byte_done && link_is_prog && !stat_s2[4]) begin
      page_buf[wr_ptr] <= next_shift;
      wr_ptr <= wr_ptr + 8'h01; // RULE23
    end
  end

  always_ff @(posedge i_sclk) begin
    if (link_cnt == `CNT_OPCODE_LAST && !stat_s2[4] &&
        (next_shift == `OPC_PAGE_PROG || next_shift == `OPC_QUAD_PROG)) begin
      page_mask <= '0;
    end else if (link_cnt >= `LEN_ADDR_CMD && link_byte_done && link_is_prog && !stat_s2[4]) begin
      page_mask[wr_ptr] <= 1'b1; // RULE3
    end
  end

  always_ff @(posedge i_sclk) begin
    stat_s1 <= {buf_lock, i_quad_data_enable_bit, suspend_flag, write_enable_latch, busy};
    stat_s2 <= stat_s1;
  end

  always_comb begin
    stat_byte = 8'h00;
    if (link_opcode == `OPC_READ_STATUS2) begin
      stat_byte[`STAT_SUSPEND_BIT] = stat_s2[2];
      stat_byte[`STAT_QUAD_BIT] = stat_s2[3];
    end else begin
      stat_byte[`STAT_BUSY_BIT] = stat_s2[0];
      stat_byte[`STAT_LATCH_BIT] = stat_s2[1];
    end
    stat_read = (link_cnt >= `LEN_OPCODE) &&
                (link_opcode == `OPC_READ_STATUS1 || link_opcode == `OPC_READ_STATUS2);
  end

  // Status shifts out on the falling edge, readable during a busy cycle
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_data_line_1 <= 1'b0;
      o_data_line_1_oe_n <= 1'b1;
    end else if (stat_read) begin
      o_data_line_1 <= stat_byte[3'h7 - link_sub]; // RULE13
      o_data_line_1_oe_n <= 1'b0;
    end
  end

  assign o_data_line_0 = 1'b0;
  assign o_data_line_2 = 1'b0;
  assign o_data_line_3 = 1'b0;
  assign o_data_line_0_oe_n = 1'b1;
  assign o_data_line_2_oe_n = 1'b1;
  assign o_data_line_3_oe_n = 1'b1;

  // Chip select crossing and frame capture
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      decode <= 1'b0;
    end else begin
      cs_s1 <= i_cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      decode <= cs_s2 && !cs_s3;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cmd_opcode <= 8'h00;
      cmd_addr <= 24'h00_0000;
      cmd_len <= 6'h00;
      cmd_aligned <= 1'b0;
    end else if (cs_s2 && !cs_s3) begin
      cmd_opcode <= link_opcode;
      cmd_addr <= link_addr;
      cmd_len <= link_len;
      cmd_aligned <= link_aligned;
    end
  end

  assign o_lock_addr = cmd_addr;

  // Decode; chip select must rise exactly after the last command bit
  always_comb begin
    new_op = OP_NONE;
    new_cycles = PROG_CYCLES;
    t_size = `SIZE_PAGE;
    unique case (cmd_opcode)
      `OPC_PAGE_PROG: begin
        if (cmd_len >= `LEN_SINGLE_MIN && cmd_aligned) begin
          new_op = OP_PROG;
        end
      end
      `OPC_QUAD_PROG: begin
        if (cmd_len >= `LEN_QUAD_MIN && cmd_aligned && i_quad_data_enable_bit) begin
          new_op = OP_PROG; // RULE1
        end
      end
      `OPC_SECTOR_ERASE: begin
        if (cmd_len == `LEN_ADDR_CMD) begin
          new_op = OP_SECTOR; // RULE6 RULE11
        end
        new_cycles = SECTOR_CYCLES;
        t_size = `SIZE_SECTOR;
      end
      `OPC_BLOCK32_ERASE: begin
        if (cmd_len == `LEN_ADDR_CMD) begin
          new_op = OP_BLOCK32; // RULE7 RULE11
        end
        new_cycles = B32_CYCLES;
        t_size = `SIZE_BLOCK32;
      end
      `OPC_BLOCK64_ERASE: begin
        if (cmd_len == `LEN_ADDR_CMD) begin
          new_op = OP_BLOCK64; // RULE8 RULE11
        end
        new_cycles = B64_CYCLES;
        t_size = `SIZE_BLOCK64;
      end
      `OPC_CHIP_ERASE_A, `OPC_CHIP_ERASE_B: begin
        if (cmd_len == `LEN_OPCODE) begin
          new_op = OP_CHIP; // RULE9 RULE12
        end
        new_cycles = CHIP_CYCLES;
        t_size = `SIZE_ARRAY;
      end
      default: begin
        new_op = OP_NONE;
      end
    endcase
  end

  // Protected range from the protection bits
  always_comb begin
    prot_code = {i_block_protect_bit2, i_block_protect_bit1, i_block_protect_bit0};
    if (prot_code == 3'h0) begin
      prot_size = 25'h000_0000;
    end else if (!i_protect_granularity_bit) begin
      prot_size = (prot_code == 3'h7) ? `SIZE_ARRAY : `SIZE_BLOCK64 << (prot_code - 3'h1);
    end else begin
      prot_size = (prot_code >= 3'h4) ? `SIZE_BLOCK32 : `SIZE_SECTOR << (prot_code - 3'h1);
    end
    if (i_protect_top_bottom_select) begin
      prot_lo = 25'h000_0000;
      prot_hi = prot_size - 25'h000_0001;
    end else begin
      prot_lo = `SIZE_ARRAY - prot_size;
      prot_hi = `SIZE_ARRAY - 25'h000_0001;
    end
    t_base = {1'b0, cmd_addr} & ~(t_size - 25'h000_0001); // RULE25
    t_end = t_base + t_size - 25'h000_0001;
    if (i_protect_complement_bit) begin
      prot_hit = !(prot_size != 25'h000_0000 && t_base >= prot_lo && t_end <= prot_hi);
    end else begin
      prot_hit = prot_size != 25'h000_0000 && t_base <= prot_hi && t_end >= prot_lo;
    end
    lock_block = (new_op == OP_CHIP) ? i_any_lock : i_lock_hit;
  end

  always_comb begin
    erase_suspended = suspend_flag && (susp_op != OP_PROG);
    prog_suspended = suspend_flag && (susp_op == OP_PROG);
    start_ok = 1'b0;
    unique case (new_op)
      OP_PROG: start_ok = !prog_suspended; // RULE20
      OP_SECTOR, OP_BLOCK32, OP_BLOCK64: start_ok = !erase_suspended; // RULE19
      OP_CHIP: start_ok = !suspend_flag; // RULE19
      default: start_ok = 1'b0;
    endcase
    // RULE4 RULE10 RULE15 RULE16
    start = decode && start_ok && !busy && write_enable_latch && !prot_hit && !lock_block;
    susp_take = decode && (cmd_opcode == `OPC_SUSPEND) && (cmd_len == `LEN_OPCODE) && // RULE17
                busy && !suspend_flag && (state == ST_RUN) && (act_op != OP_CHIP); // RULE18
    resume_take = decode && (cmd_opcode == `OPC_RESUME) && (cmd_len == `LEN_OPCODE) &&
                  suspend_flag && !busy; // RULE24
    latch_set = decode && (cmd_opcode == `OPC_WRITE_ENABLE) && (cmd_len == `LEN_OPCODE) && !busy;
    latch_clr = decode && (cmd_opcode == `OPC_WRITE_DISABLE) && (cmd_len == `LEN_OPCODE) && !busy;
    accepted = start || susp_take || resume_take || latch_set || latch_clr;
    op_done = ((state == ST_RUN) && !susp_take && (act_remain == 32'h0000_0001) &&
               (act_op != OP_PROG)) || ((state == ST_FLUSH) && (flush_idx == `PAGE_LAST));
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start || resume_take) begin
          next_state = ST_RUN; // RULE13 RULE24
        end
      end
      ST_RUN: begin
        if (susp_take) begin
          next_state = ST_IDLE; // RULE21
        end else if (act_remain == 32'h0000_0001) begin
          next_state = (act_op == OP_PROG) ? ST_FLUSH : ST_IDLE;
        end
      end
      ST_FLUSH: begin
        if (flush_idx == `PAGE_LAST) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      buf_lock <= 1'b0;
    end else begin
      state <= next_state;
      busy <= (next_state != ST_IDLE); // RULE13
      buf_lock <= (next_state != ST_IDLE) || prog_suspended || susp_take;
    end
  end

  // Active and suspended operation context
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      act_op <= OP_NONE;
      act_addr <= 24'h00_0000;
      act_remain <= 32'h0000_0000;
      susp_op <= OP_NONE;
      susp_addr <= 24'h00_0000;
      susp_remain <= 32'h0000_0000;
    end else if (start) begin
      act_op <= new_op;
      act_addr <= t_base[23:0];
      act_remain <= new_cycles;
    end else if (resume_take) begin
      act_op <= susp_op;
      act_addr <= susp_addr;
      act_remain <= susp_remain;
    end else if (susp_take) begin
      susp_op <= act_op;
      susp_addr <= act_addr;
      susp_remain <= act_remain;
    end else if (state == ST_RUN) begin
      act_remain <= act_remain - 32'h0000_0001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      write_enable_latch <= 1'b0;
    end else if (op_done) begin
      write_enable_latch <= 1'b0; // RULE14
    end else if (latch_set) begin
      write_enable_latch <= 1'b1;
    end else if (latch_clr) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      suspend_flag <= 1'b0;
    end else if (susp_take) begin
      suspend_flag <= 1'b1; // RULE21
    end else if (resume_take) begin
      suspend_flag <= 1'b0; // RULE24
    end
  end

  // Array writes after the timed cycle; cells only go from one to zero
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flush_idx <= 8'h00;
      o_arr_wr <= 1'b0;
      o_arr_addr <= 24'h00_0000;
      o_arr_wdata <= 8'h00;
      o_arr_erase <= 1'b0;
      o_arr_erase_kind <= OP_NONE;
      o_arr_erase_base <= 24'h00_0000;
    end else begin
      o_arr_wr <= 1'b0;
      o_arr_erase <= 1'b0;
      if (state == ST_FLUSH) begin
        flush_idx <= flush_idx + 8'h01;
        o_arr_wr <= page_mask[flush_idx]; // RULE3
        o_arr_addr <= {act_addr[23:8], flush_idx};
        o_arr_wdata <= page_buf[flush_idx];
      end else begin
        flush_idx <= 8'h00;
      end
      if (op_done && state == ST_RUN) begin
        o_arr_erase <= 1'b1; // RULE6 RULE7 RULE8 RULE9
        o_arr_erase_kind <= act_op;
        o_arr_erase_base <= act_addr;
      end
    end
  end

  assign o_busy = busy;
  assign o_write_enable_latch = write_enable_latch;
  assign o_suspend_flag = suspend_flag;
  assign o_status_write_blocked = suspend_flag; // RULE19 RULE20

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_quad_enable;
    decode && !busy && (cmd_opcode == `OPC_QUAD_PROG) && !i_quad_data_enable_bit |=> !busy;
  endproperty
  a_quad_enable: assert property (p_quad_enable) else $error("quad enable ignored"); // RULE1

  property p_flush_len;
    (state == ST_FLUSH) && (flush_idx == 8'h00) |-> ##255 (state == ST_FLUSH) ##1 !busy;
  endproperty
  a_flush_len: assert property (p_flush_len) else $error("page write-out not 256"); // RULE3

  property p_latch_start;
    $rose(busy) && !$past(resume_take) |-> $past(write_enable_latch);
  endproperty
  a_latch_start: assert property (p_latch_start) else $error("start without latch"); // RULE4

  property p_latch_clear;
    op_done |=> !write_enable_latch && !busy;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared"); // RULE14

  property p_prot;
    decode && !busy && (new_op != OP_NONE) && (prot_hit || lock_block) |=> !busy;
  endproperty
  a_prot: assert property (p_prot) else $error("protected erase started"); // RULE15

  property p_suspend;
    susp_take |=> suspend_flag && !busy ##1 suspend_flag;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend not taken"); // RULE21

  property p_chip_nosusp;
    busy && (act_op == OP_CHIP) && decode && !op_done |=> busy && !suspend_flag;
  endproperty
  a_chip_nosusp: assert property (p_chip_nosusp) else $error("chip erase suspended"); // RULE18

  property p_resume;
    resume_take |=> !suspend_flag ##[0:RESUME_MAX] busy;
  endproperty
  a_resume: assert property (p_resume) else $error("resume busy late"); // RULE24

  property p_reject;
    decode && !accepted && !op_done |=> $stable(busy) && $stable(suspend_flag) &&
      $stable(write_enable_latch);
  endproperty
  a_reject: assert property (p_reject) else $error("rejected command changed state"); // RULE26

  property p_erase_susp;
    decode && !busy && erase_suspended && (new_op != OP_NONE) && (new_op != OP_PROG) |=> !busy;
  endproperty
  a_erase_susp: assert property (p_erase_susp) else $error("erase during erase suspend"); // RULE19

endmodule

// ===== verification/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_dat
);
  // A short chip select pulse at start gives the link counters a clean clear edge
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_dat = 4'h0;
    #5 o_cs_n = 1'b1;
  end
  task automatic tick(input logic [3:0] v);
    o_dat = v;
    #7.5 o_sclk = 1'b1;
    #7.5 o_sclk = 1'b0;
  endtask
  // Line 0 carries opcode and address MSB first, then quad data high nibble first
  task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int na,
                       input int nq, input logic [7:0] qd);
    logic [31:0] sr;
    sr = {op, adr};
    #60 o_cs_n = 1'b0;
    for (int i = 0; i < 8 + na; i++) tick({~o_dat[3:1], sr[31 - i]});
    for (int i = 0; i < 2 * nq; i++) tick(i[0] ? qd[3:0] : qd[7:4]);
    #7.5 o_cs_n = 1'b1;
    o_dat = ~o_dat;
    #150;
  endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import flash_pes_pkg::*;
  logic mclk, rst, quad_en, lock_hit, any_lock, busy, latch, susp, blk, q1, q1_oe_n, d1;
  logic sclk, cs_n, arr_wr, arr_erase;
  logic [5:0] prot;
  logic [3:0] hd;
  logic [23:0] arr_addr, ebase;
  logic [7:0] wdata;
  logic [7:0] rd;
  logic [26:0] elast;
  op_e ekind;
  int error_cnt = 0;
  int checked = 0;
  int ecnt = 0;
  logic [31:0] wq[$];
  logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  int lens[5] = '{24, 24, 24, 0, 0};
  op_e kinds[5] = '{OP_SECTOR, OP_BLOCK32, OP_BLOCK64, OP_CHIP, OP_CHIP};
  logic [23:0] bases[5] = '{24'h01_2000, 24'h01_0000, 24'h01_0000, 24'h00_0000, 24'h00_0000};
  assign d1 = q1_oe_n ? hd[1] : q1;
  spi_host_model spi_host_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_dat(hd));
  flash_program_erase_suspend #(.PROG_TIME_NS(200), .SECTOR_ERASE_DURATION_NS(20000),
    .HALF_BLOCK_ERASE_DURATION_NS(20000), .BLOCK_ERASE_TIME_NS(20000),
    .CHIP_ERASE_TIME_NS(20000)) flash_program_erase_suspend_i (
    .i_mclk(mclk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_data_line_0(hd[0]),
    .i_data_line_1(d1), .i_data_line_2(hd[2]), .i_data_line_3(hd[3]),
    .o_data_line_0(), .o_data_line_1(q1), .o_data_line_2(), .o_data_line_3(),
    .o_data_line_0_oe_n(), .o_data_line_1_oe_n(q1_oe_n), .o_data_line_2_oe_n(),
    .o_data_line_3_oe_n(), .i_quad_data_enable_bit(quad_en), .i_block_protect_bit0(prot[0]),
    .i_block_protect_bit1(prot[1]), .i_block_protect_bit2(prot[2]),
    .i_protect_top_bottom_select(prot[3]), .i_protect_granularity_bit(prot[4]),
    .i_protect_complement_bit(prot[5]), .i_lock_hit(lock_hit), .i_any_lock(any_lock),
    .o_busy(busy), .o_write_enable_latch(latch), .o_suspend_flag(susp),
    .o_status_write_blocked(blk), .o_lock_addr(), .o_arr_wr(arr_wr), .o_arr_addr(arr_addr),
    .o_arr_wdata(wdata), .o_arr_erase(arr_erase), .o_arr_erase_kind(ekind),
    .o_arr_erase_base(ebase));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Status bits come out on falling link edges, so the rising edge sees them settled
  always @(posedge sclk) begin
    if (!cs_n) rd <= {rd[6:0], q1};
  end
  // Array pulses are sampled away from the edge that launches them
  always @(negedge mclk) begin
    if (arr_erase === 1'b1) begin
      ecnt++;
      elast = {ekind, ebase};
    end
    if (arr_wr === 1'b1) wq.push_back({arr_addr, wdata});
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wbusy(input logic v);
    int n;
    n = 0;
    while (busy !== v) begin
      @(negedge mclk);
      n++;
      if (n > 3000) begin
        error_cnt++;
        end_of_test();
      end
    end
    // One more edge lets the monitor catch pulses launched with the busy change
    @(negedge mclk);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] adr, input int na);
    spi_host_model_i.frame(op, adr, na, 0, 8'h00);
  endtask
  // Decode lands within a few cycles, so 20 idle cycles show a refusal
  task automatic nobusy;
    repeat (20) @(negedge mclk);
    chk(busy, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    quad_en = 1'b0;
    prot = 6'h00;
    lock_hit = 1'b0;
    any_lock = 1'b0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    chk({busy, latch, susp, blk}, 4'h0);
    for (int k = 0; k < 5; k++) begin
      cmd(8'h06, 24'h0, 0);
      cmd(ops[k], 24'h01_2345, lens[k]);
      wbusy(1'b1);
      chk(latch, 1'b1);
      wbusy(1'b0);
      chk(latch, 1'b0);
      chk(ecnt, k + 1);
      chk(elast, {kinds[k], bases[k]});
    end
    cmd(8'h20, 24'h00_1000, 24);
    nobusy();
    cmd(8'h06, 24'h0, 0);
    cmd(8'h20, 24'h00_1000, 23);
    nobusy();
    cmd(8'hC7, 24'h0, 8);
    nobusy();
    @(negedge mclk);
    prot = 6'h01;
    cmd(8'h20, 24'hFF_1000, 24);
    nobusy();
    @(negedge mclk);
    prot = 6'h21;
    cmd(8'h20, 24'h00_1000, 24);
    nobusy();
    @(negedge mclk);
    prot = 6'h00;
    lock_hit = 1'b1;
    cmd(8'h52, 24'h00_8000, 24);
    nobusy();
    @(negedge mclk);
    lock_hit = 1'b0;
    any_lock = 1'b1;
    cmd(8'h60, 24'h0, 0);
    nobusy();
    @(negedge mclk);
    any_lock = 1'b0;
    chk(latch, 1'b1);
    chk(ecnt, 32'h0000_0005);
    spi_host_model_i.frame(8'h32, 24'h00_00FE, 24, 3, 8'hA5);
    nobusy();
    @(negedge mclk);
    quad_en = 1'b1;
    spi_host_model_i.frame(8'h32, 24'h00_00FE, 24, 3, 8'hA5);
    wbusy(1'b1);
    wbusy(1'b0);
    wq.sort();
    chk(wq.size(), 3);
    chk(wq[0], 32'h0000_00A5);
    chk(wq[1], 32'h0000_FEA5);
    chk(wq[2], 32'h0000_FFA5);
    chk(latch, 1'b0);
    spi_host_model_i.frame(8'h32, 24'h00_0010, 24, 1, 8'h5A);
    nobusy();
    cmd(8'h06, 24'h0, 0);
    cmd(8'h04, 24'h0, 0);
    cmd(8'h20, 24'h00_2000, 24);
    nobusy();
    chk(latch, 1'b0);
    cmd(8'h06, 24'h0, 0);
    cmd(8'h20, 24'h00_2000, 24);
    wbusy(1'b1);
    cmd(8'h05, 24'h0, 8);
    chk(rd, 8'h03);
    cmd(8'h75, 24'h0, 0);
    repeat (10) @(negedge mclk);
    chk({susp, busy, blk}, 3'b101);
    cmd(8'h35, 24'h0, 8);
    chk(rd, 8'h82);
    cmd(8'h06, 24'h0, 0);
    cmd(8'h20, 24'h00_3000, 24);
    nobusy();
    cmd(8'h7A, 24'h0, 0);
    repeat (10) @(negedge mclk);
    chk({susp, busy}, 2'b01);
    wbusy(1'b0);
    cmd(8'h75, 24'h0, 0);
    nobusy();
    cmd(8'h7A, 24'h0, 0);
    nobusy();
    chk(susp, 1'b0);
    cmd(8'h06, 24'h0, 0);
    cmd(8'hC7, 24'h0, 0);
    wbusy(1'b1);
    cmd(8'h75, 24'h0, 0);
    repeat (10) @(negedge mclk);
    chk({susp, busy}, 2'b01);
    wbusy(1'b0);
    end_of_test();
  end
endmodule
